// ==== core/eeprom_pkg.sv ====
package eeprom_pkg;
	// Device-type field of the slave address; value is arbitrary
	localparam logic [3:0] DEV_TYPE = 4'h6;
	localparam int PAGE_BYTES = 16;
	localparam int BLOCK_BITS = 8;
	localparam int CLK_MHZ = 200;
	// Self-timed programming time, standard and low-voltage parts
	localparam int T_WR_STD_MS = 10;
	localparam int T_WR_LV_MS = 15;
	localparam int WR_CYC_STD = T_WR_STD_MS * CLK_MHZ * 1000;
	localparam int WR_CYC_LV = T_WR_LV_MS * CLK_MHZ * 1000;
	// Quarter of a serial clock period driven by the controller
	localparam int T_QTR_NS = 1250;
	localparam int QTR_CYCLES = T_QTR_NS * CLK_MHZ / 1000;
	// Controller register byte offsets
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	// Command word fields
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_READ = 2;
	localparam int CMD_ACK = 3;
	localparam int CMD_DATA = 8;
	// Status word fields
	localparam int ST_BUSY = 0;
	localparam int ST_NACK = 1;
	localparam int ST_DATA = 8;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_WORD = 3'b010,
		S_DATA = 3'b011,
		S_READ = 3'b100,
		S_WAIT = 3'b101
	} dev_state_t;
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_START = 2'b01,
		M_BIT = 2'b10,
		M_STOP = 2'b11
	} mst_state_t;
endpackage

// ==== core/two_wire_if.sv ====
`timescale 1ns/1ps
interface two_wire_if;
	// Clock is driven only by the controller
	logic scl_o;
	logic scl_i;
	// Open-drain data: each end pulls low while its enable is high
	logic m_sda_o;
	logic m_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic sda_i;

	// Clock passed straight through; data is a wired-AND with pull-up
	assign scl_i = scl_o;
	assign sda_i = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

	modport ctrl (output scl_o, output m_sda_o, output m_sda_oe, input sda_i);
	modport dev (input scl_i, input sda_i, output d_sda_o, output d_sda_oe);
endinterface

// ==== core/eeprom_device.sv ====
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Slave address upper four bits: device type
// [RULE2] 2K-bit blocks, byte address 00 to FF
// [RULE3] Density decides how many select bits
// [RULE4] Last address bit: 1 read, 0 write
// [RULE5] Matching address gets acknowledge, then wait
// [RULE6] Write: word address follows, acknowledged
// [RULE7] Data bytes acknowledged; stop starts programming
// [RULE8] Busy programming: no acknowledge, no answer
// [RULE9] Page write up to sixteen bytes
// [RULE10] Write counter wraps inside the page
// [RULE11] Polling: address nacked while busy
// [RULE12] Write protect: nack first data, no program
// [RULE13] Shared counter holds last address plus one
// [RULE14] Current-address read sends one byte
// [RULE15] Random read: dummy write then read
// [RULE16] Sequential read continues while master acknowledges
// [RULE17] Read counter wraps across whole array
// [RULE18] Programming time 10 ms, 15 ms low-voltage
// [RULE19] No master acknowledge: stop sending, await stop
// [RULE20] Select pin mismatch: ignore until next start
module eeprom_device #(
	parameter int PB_BITS = 3,
	parameter int WR_CYCLES = eeprom_pkg::WR_CYC_STD
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial bus
	two_wire_if.dev bus,
	// Straps and status
	input wire logic select_pin_0,
	input wire logic select_pin_1,
	input wire logic select_pin_2,
	input wire logic wp,
	output logic busy
);
	import eeprom_pkg::*;

	localparam int AW = BLOCK_BITS + PB_BITS;
	localparam int DEPTH = 1 << AW;

	logic [1:0] scl_ff, sda_ff;
	logic scl_p, sda_p;
	logic [3:0] pin_ff0, pin_ff1;
	logic scl_s, sda_s, start_ev, stop_ev, rise, fall;
	dev_state_t st_q;
	logic [3:0] bit_q;
	logic [7:0] sr_q, tx_q;
	logic ack_q, tx_en_q, rw_q, mack_q, wr_any_q;
	logic [2:0] sel_q;
	logic [AW-1:0] addr_q;
	logic [31:0] wr_cnt_q;
	logic prog_go, commit, data_ok;
	logic [7:0] pg_data_q [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pg_mask_q;
	logic [AW-5:0] pg_base_q;
	logic [7:0] mem_q [DEPTH];

	// Compare type field and the hardware-strapped select bits
	function automatic logic addr_hit(logic [7:0] b, logic [2:0] pins);
		logic ok;
		ok = (b[7:4] == DEV_TYPE); // see [RULE1]
		for (int i = 0; i < 3; i++)
			if (i >= PB_BITS && b[i + 1] != pins[i])
				ok = 1'b0; // see [RULE3]
		return ok;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; bus pins get an extra stage for edge detection
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			scl_ff <= 2'h3;
			sda_ff <= 2'h3;
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			pin_ff0 <= 4'h0;
			pin_ff1 <= 4'h0;
		end
		else
		begin
			scl_ff <= {scl_ff[0], bus.scl_i};
			sda_ff <= {sda_ff[0], bus.sda_i};
			scl_p <= scl_ff[1];
			sda_p <= sda_ff[1];
			pin_ff0 <= {wp, select_pin_2, select_pin_1, select_pin_0};
			pin_ff1 <= pin_ff0;
		end
	end

	// Bus events seen on the synchronised lines
	assign scl_s = scl_ff[1];
	assign sda_s = sda_ff[1];
	assign start_ev = scl_s && scl_p && sda_p && !sda_s;
	assign stop_ev = scl_s && scl_p && !sda_p && sda_s;
	assign rise = scl_s && !scl_p;
	assign fall = !scl_s && scl_p;

	////////////////////////////////////////////////////////////////////////
	// Self-timed programming; commit happens on the last count
	assign busy = (wr_cnt_q != 32'h0);
	assign commit = (wr_cnt_q == 32'h1);
	assign prog_go = stop_ev && st_q == S_DATA && wr_any_q && !busy; // see [RULE7]

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wr_cnt_q <= 32'h0;
		else if (prog_go)
			wr_cnt_q <= 32'(WR_CYCLES); // see [RULE18]
		else if (busy)
			wr_cnt_q <= wr_cnt_q - 32'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Protocol engine: bits shift on the rise, ack/data change on the fall
	assign data_ok = !pin_ff1[3];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= S_IDLE;
			bit_q <= 4'h0;
			sr_q <= 8'h00;
			tx_q <= 8'hFF;
			ack_q <= 1'b0;
			tx_en_q <= 1'b0;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			wr_any_q <= 1'b0;
			sel_q <= 3'h0;
			addr_q <= '0;
		end
		else if (stop_ev)
		begin
			st_q <= S_IDLE;
			bit_q <= 4'h0;
			ack_q <= 1'b0;
			tx_en_q <= 1'b0;
		end
		else if (start_ev)
		begin
			// Inputs are shut while programming runs
			st_q <= busy ? S_IDLE : S_ADDR; // see [RULE8] see [RULE11]
			// The clock fall that closes the start is not a bit; it wraps to 0
			bit_q <= 4'hF;
			ack_q <= 1'b0;
			tx_en_q <= 1'b0;
			wr_any_q <= 1'b0;
		end
		else if (rise && bit_q != 4'h8)
			sr_q <= {sr_q[6:0], sda_s};
		else if (rise)
			mack_q <= !sda_s;
		else if (fall && bit_q == 4'h7)
		begin
			bit_q <= 4'h8;
			tx_en_q <= 1'b0;
			case (st_q)
				S_ADDR:
					if (addr_hit(sr_q, pin_ff1[2:0]))
					begin
						ack_q <= 1'b1; // see [RULE5]
						rw_q <= sr_q[0]; // see [RULE4]
						sel_q <= sr_q[3:1];
					end
					else
						st_q <= S_WAIT; // see [RULE20]
				S_WORD:
				begin
					ack_q <= 1'b1; // see [RULE6]
					addr_q <= AW'({sel_q, sr_q}); // see [RULE2]
				end
				S_DATA:
					if (data_ok)
					begin
						ack_q <= 1'b1; // see [RULE9]
						wr_any_q <= 1'b1;
						addr_q <= {addr_q[AW-1:4], addr_q[3:0] + 4'h1}; // see [RULE10]
					end
					else
						st_q <= S_WAIT; // see [RULE12]
				default:
					;
			endcase
		end
		else if (fall && bit_q == 4'h8)
		begin
			bit_q <= 4'h0;
			ack_q <= 1'b0;
			case (st_q)
				S_ADDR:
					if (rw_q)
					begin
						st_q <= S_READ; // see [RULE14] see [RULE15]
						tx_q <= mem_q[addr_q]; // see [RULE13]
						tx_en_q <= 1'b1;
						addr_q <= addr_q + 1'b1;
					end
					else
						st_q <= S_WORD;
				S_WORD:
					st_q <= S_DATA;
				S_READ:
					if (mack_q)
					begin
						tx_q <= mem_q[addr_q]; // see [RULE16]
						tx_en_q <= 1'b1;
						addr_q <= addr_q + 1'b1; // see [RULE17]
					end
					else
						st_q <= S_WAIT; // see [RULE19]
				default:
					;
			endcase
		end
		else if (fall)
		begin
			bit_q <= bit_q + 4'h1;
			tx_q <= {tx_q[6:0], 1'b1};
		end
	end

	// Only ever pull low; released otherwise
	assign bus.d_sda_o = 1'b0;
	assign bus.d_sda_oe = ack_q || (tx_en_q && !tx_q[7]);

	////////////////////////////////////////////////////////////////////////
	// Page buffer collects bytes until the stop; mask marks loaded slots
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pg_mask_q <= '0;
			pg_base_q <= '0;
			for (int i = 0; i < PAGE_BYTES; i++)
				pg_data_q[i] <= 8'h00;
		end
		else if (start_ev && !busy)
			pg_mask_q <= '0;
		else if (fall && bit_q == 4'h7 && st_q == S_DATA && data_ok)
		begin
			pg_data_q[addr_q[3:0]] <= sr_q; // see [RULE10]
			pg_mask_q[addr_q[3:0]] <= 1'b1;
			pg_base_q <= addr_q[AW-1:4];
		end
	end

	// Array in flops; loaded page bytes land when programming time ends
	always_ff @(posedge clk)
	begin
		if (commit)
			for (int i = 0; i < PAGE_BYTES; i++)
				if (pg_mask_q[i])
					mem_q[{pg_base_q, 4'(i)}] <= pg_data_q[i]; // see [RULE7]
	end
endmodule

// ==== core/eeprom_master.sv ====
`timescale 1ns/1ps
module eeprom_master #(
	parameter int QTR = eeprom_pkg::QTR_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM register port
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Serial bus
	two_wire_if.ctrl bus
);
	import eeprom_pkg::*;

	logic [1:0] sda_ff;
	logic [15:0] qcnt_q;
	logic tick, go, rd_q;
	mst_state_t st_q;
	logic [1:0] q_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, rx_q;
	logic start_q, stop_q, read_q, ack_q, nack_q, scl_q, sda_q;

	////////////////////////////////////////////////////////////////////////
	// Register port: a command write stalls while a byte is in flight
	assign go = write && address == REG_CMD && st_q == M_IDLE;
	assign waitrequest = (write && address == REG_CMD && st_q != M_IDLE) ||
		(read && !rd_q);

	// Reads take one wait state so readdata comes from a flop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_q <= 1'b0;
			readdata <= 32'h0;
		end
		else
		begin
			rd_q <= read && !rd_q;
			if (read && address == REG_STATUS)
				readdata <= {16'h0, rx_q, 6'h0, nack_q, st_q != M_IDLE};
			else
				readdata <= 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Quarter-period divider, restarted by each command
	assign tick = (qcnt_q == 16'h0);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			qcnt_q <= 16'h0;
		else if (go || tick)
			qcnt_q <= 16'(QTR - 1);
		else
			qcnt_q <= qcnt_q - 16'h1;
	end

	// Data line comes from outside the domain
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sda_ff <= 2'h3;
		else
			sda_ff <= {sda_ff[0], bus.sda_i};
	end

	////////////////////////////////////////////////////////////////////////
	// Bit sequencer: four quarters per start, bit or stop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= M_IDLE;
			q_q <= 2'h0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rx_q <= 8'h00;
			start_q <= 1'b0;
			stop_q <= 1'b0;
			read_q <= 1'b0;
			ack_q <= 1'b0;
			nack_q <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else if (go)
		begin
			start_q <= writedata[CMD_START];
			stop_q <= writedata[CMD_STOP];
			read_q <= writedata[CMD_READ];
			ack_q <= writedata[CMD_ACK];
			sh_q <= writedata[CMD_DATA +: 8];
			st_q <= writedata[CMD_START] ? M_START : M_BIT;
			q_q <= 2'h0;
			bit_q <= 4'h0;
		end
		else if (tick && st_q != M_IDLE)
		begin
			q_q <= q_q + 2'h1;
			case (st_q)
				M_START:
					case (q_q)
						2'h0: sda_q <= 1'b1;
						2'h1: scl_q <= 1'b1;
						2'h2: sda_q <= 1'b0;
						default:
						begin
							scl_q <= 1'b0;
							st_q <= M_BIT;
						end
					endcase
				M_BIT:
					case (q_q)
						2'h0:
							if (bit_q == 4'h8)
								sda_q <= read_q ? !ack_q : 1'b1;
							else
								sda_q <= read_q ? 1'b1 : sh_q[7];
						2'h1: scl_q <= 1'b1;
						2'h2:
							if (bit_q == 4'h8)
								nack_q <= sda_ff[1];
							else
								sh_q <= {sh_q[6:0], sda_ff[1]};
						default:
						begin
							scl_q <= 1'b0;
							bit_q <= bit_q + 4'h1;
							if (bit_q == 4'h8)
							begin
								rx_q <= sh_q;
								st_q <= stop_q ? M_STOP : M_IDLE;
							end
						end
					endcase
				M_STOP:
					case (q_q)
						2'h0: sda_q <= 1'b0;
						2'h1: scl_q <= 1'b1;
						2'h2: sda_q <= 1'b1;
						default: st_q <= M_IDLE;
					endcase
				default:
					st_q <= M_IDLE;
			endcase
		end
	end

	// Clock is push-pull; data is open drain
	assign bus.scl_o = scl_q;
	assign bus.m_sda_o = 1'b0;
	assign bus.m_sda_oe = !sda_q;
endmodule

// ==== tb/eeprom_assertions.sv ====
`timescale 1ns/1ps
module eeprom_assertions #(
	parameter int WR_CYCLES = 2000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Serial wires
	input wire logic scl_o,
	input wire logic scl_i,
	input wire logic m_sda_oe,
	input wire logic d_sda_oe,
	input wire logic sda_i,
	// Device status
	input wire logic busy
);
	int cnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// Length of the programming window, cleared when idle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= 0;
		else if (busy)
			cnt_q <= cnt_q + 1;
		else
			cnt_q <= 0;
	end
	////////////////////////////////////////////////////////////////
	// Two clocks of slack cover the status decode delay
	chk_busy_silent:
		assert property (busy |-> !d_sda_oe) else $error("drive while busy");
	chk_busy_max:
		assert property (busy |-> cnt_q <= WR_CYCLES + 2)
		else $error("programming too long");
	chk_busy_min:
		assert property ($fell(busy) |-> cnt_q >= WR_CYCLES - 2)
		else $error("programming too short");
	chk_prog_on_stop:
		assert property ($rose(busy) |-> scl_i && sda_i)
		else $error("programming began without stop");
	chk_ack_scl_low:
		assert property ($rose(d_sda_oe) |-> !scl_i)
		else $error("device drove data with clock high");
	chk_drive_held:
		assert property ($rose(scl_i) && d_sda_oe |-> d_sda_oe [*8])
		else $error("device drive dropped with clock high");
	// Both ends may pull low together while the clock is low (open drain);
	// with the clock high only the owner of the bit may drive
	chk_no_clash:
		assert property (d_sda_oe && scl_i |-> !m_sda_oe)
		else $error("both ends drive data");
	chk_scl_high_min:
		assert property ($rose(scl_o) |-> scl_o [*8])
		else $error("clock high too short");
	// Main scenarios reached
	cover property ($rose(busy));
	cover property ($fell(busy));
	cover property ($rose(d_sda_oe));
endmodule

// ==== tb/serial_eeprom_slave_access_tb_top.sv ====
`timescale 1ns/1ps
module serial_eeprom_slave_access_tb_top;
	import eeprom_pkg::*;
	logic clk, rst, read, write, wp, busy, waitrequest;
	logic [3:0] address;
	logic [31:0] writedata, readdata, st;
	logic [7:0] q[$];
	logic [2:0] straps;
	int num_errors, cmp_count;
	two_wire_if bus_if ();
	eeprom_master #(.QTR(10)) eeprom_master_inst (.clk(clk), .rst(rst),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .bus(bus_if.ctrl));
	// Pins 2 and 1 compared, the lowest select bit picks the block
	eeprom_device #(.PB_BITS(1), .WR_CYCLES(2000)) eeprom_device_inst (
		.clk(clk), .rst(rst), .bus(bus_if.dev), .select_pin_0(straps[0]),
		.select_pin_1(straps[1]), .select_pin_2(straps[2]), .wp(wp),
		.busy(busy));
	eeprom_assertions #(.WR_CYCLES(2000)) eeprom_assertions_inst (
		.clk(clk), .rst(rst), .scl_o(bus_if.scl_o), .scl_i(bus_if.scl_i),
		.m_sda_oe(bus_if.m_sda_oe), .d_sda_oe(bus_if.d_sda_oe),
		.sda_i(bus_if.sda_i), .busy(busy));
	////////////////////////////////////////////////////////////////
	// Clock
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task results;
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task fail;
		num_errors++;
		results;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [7:0] sa(input logic b, input logic r);
		return {DEV_TYPE, 2'b01, b, r};
	endfunction
	// Waitrequest and readdata are taken at the rising edge itself;
	// the request is released only after that edge
	task av(input logic rd, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		read <= rd;
		write <= !rd;
		address <= a;
		writedata <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 1000);
		st = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (waitrequest !== 1'b0)
			fail;
	endtask
	// One byte on the wire, then wait for the sequencer to go idle
	task xf(input logic [3:0] f, input logic [7:0] b);
		int n;
		av(0, REG_CMD, {16'h0, b, 4'h0, f});
		for (n = 0; n < 500; n++)
		begin
			av(1, REG_STATUS, 32'h0);
			if (st[ST_BUSY] === 1'b0)
				break;
		end
		if (n == 500)
			fail;
	endtask
	task wr(input logic b, input logic [7:0] w, input logic dn);
		xf(4'h1, sa(b, 0));
		chk("addr ack", st[ST_NACK], 0);
		xf(4'h0, w);
		chk("word ack", st[ST_NACK], 0);
		foreach (q[i])
		begin
			xf(i == q.size() - 1 ? 4'h2 : 4'h0, q[i]);
			chk("data ack", st[ST_NACK], i == 0 && dn);
		end
	endtask
	// Polling with a write address until it is acknowledged
	task ready(input logic b1);
		int n;
		for (n = 0; n < 20; n++)
		begin
			xf(4'h3, sa(0, 0));
			if (n == 0)
				chk("poll ack", st[ST_NACK], b1);
			if (st[ST_NACK] === 1'b0)
				break;
		end
		if (n == 20)
			fail;
	endtask
	task rd(input logic b, input logic [7:0] w);
		xf(4'h1, sa(b, 0));
		xf(4'h0, w);
		xf(4'h1, sa(b, 1));
		chk("read addr ack", st[ST_NACK], 0);
		foreach (q[i])
		begin
			xf(i == q.size() - 1 ? 4'h6 : 4'hC, 8'hFF);
			chk("read data", st[15:8], q[i]);
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Eighteen bytes from F8 roll over inside the page
	task t_page;
		q = {};
		for (int i = 0; i < 18; i++)
			q.push_back(8'h40 + 8'(i));
		wr(1, 8'hF8, 0);
		ready(1);
		q = {};
		for (int k = 0; k < 16; k++)
			q.push_back(k < 10 ? 8'h48 + 8'(k) : 8'h38 + 8'(k));
		rd(1, 8'hF0);
	endtask
	task t_wrap;
		q = {8'h5A, 8'hA5};
		wr(0, 8'h00, 0);
		ready(1);
		q = {8'hC3};
		wr(1, 8'hFF, 0);
		ready(1);
		q = {8'hC3, 8'h5A};
		rd(1, 8'hFF);
		xf(4'h1, sa(0, 1));
		xf(4'h6, 8'hFF);
		chk("current read", st[15:8], 8'hA5);
	endtask
	task t_protect;
		wp <= 1;
		q = {8'h11};
		wr(0, 8'h00, 1);
		ready(0);
		wp <= 0;
		q = {8'h5A};
		rd(0, 8'h00);
	endtask
	task t_foreign;
		xf(4'h3, {DEV_TYPE ^ 4'h1, 4'h4});
		chk("type nack", st[ST_NACK], 1);
		xf(4'h3, {DEV_TYPE, 4'hC});
		chk("strap nack", st[ST_NACK], 1);
		// Same address once the straps are moved to match it
		straps <= 3'h6;
		xf(4'h3, {DEV_TYPE, 4'hC});
		chk("strap ack", st[ST_NACK], 0);
	endtask
	// Reset, then the scenarios in turn
	initial
	begin
		rst = 1;
		read = 0;
		write = 0;
		wp = 0;
		straps = 3'h2;
		address = 4'h0;
		writedata = 32'h0;
		repeat (12) @(posedge clk);
		rst <= 0;
		repeat (4) @(posedge clk);
		t_page;
		t_wrap;
		t_protect;
		t_foreign;
		results;
	end
endmodule
